// ### include/sdom_pkg.sv
// constants and source map for the signal to drive order mapper
package sdom_pkg;

  // ****************************************************************
  // signal source index space
  // ****************************************************************
  localparam int Q_W = 7;
  localparam int Q_N = 70;
  localparam int ORDER_W = 3;
  localparam int DISC_W = 16;

  // digital input sources, three outputs each (rise, fall, level)
  localparam int DI_N = 5;
  localparam int DI_BASE = 2;
  localparam int DI_STRIDE = 3;

  // status bit sources, four outputs each
  localparam int STAT_N = 5;
  localparam int STAT_BASE = 44;
  localparam int STAT_STRIDE = 4;
  localparam int OFS_RISE = 0;
  localparam int OFS_FALL = 1;
  localparam int OFS_LEVEL = 2;
  localparam int OFS_INV = 3;

  // ****************************************************************
  // logic gate outputs
  // ****************************************************************
  localparam int AND_N = 3;
  localparam int AND_IN = 4;
  localparam int OR_N = 2;
  localparam int OR_IN = 4;
  localparam int NOT_N = 2;
  localparam int AND_Q [AND_N] = '{17, 18, 64};
  localparam int OR_Q [OR_N] = '{19, 20};
  localparam int NOT_Q [NOT_N] = '{21, 22};
  // gates 0 and 2 carry the discrepancy watch
  localparam logic [AND_N-1:0] AND_DISC = 3'h5;

  localparam logic [DISC_W-1:0] DISC_ONE = 16'h0001;

  // edge outputs give one-cycle pulses, so their orders must latch
  function automatic logic is_edge_src(input logic [Q_W-1:0] idx);
    int i;
    logic r;
    i = int'(idx);
    r = 1'b0;
    if (i >= DI_BASE && i < DI_BASE + DI_N * DI_STRIDE) begin
      r = ((i - DI_BASE) % DI_STRIDE) < OFS_LEVEL;
    end
    // edge outputs sit below the level slot of each source
    if (i >= STAT_BASE && i < STAT_BASE + STAT_N * STAT_STRIDE) begin
      r = ((i - STAT_BASE) % STAT_STRIDE) < OFS_LEVEL;
    end
    return r;
  endfunction

endpackage

// ### verif/sdom_drive_model.sv
// drive sequencer model that finishes the latched order of slot 0 only
`timescale 1ns/1ps
`default_nettype none

module sdom_drive_model #(
  parameter int SLOT_N = 8,
  parameter int DLY = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [SLOT_N-1:0] order_active,
  output logic [SLOT_N-1:0] slot_done
);
  int cnt;

  // slot 0 only: level slots are never finished by the drive
  always_ff @(posedge clk_sys) begin
    slot_done <= '0;
    if (srst || !order_active[0]) begin
      cnt <= 0;
    end else if (cnt == DLY) begin
      slot_done[0] <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

`default_nettype wire

// ### verif/sdom_mapper_asserts.sv
// port assertions for the mapper
`timescale 1ns/1ps
`default_nettype none

module sdom_mapper_asserts #(
  parameter int SLOT_N = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [sdom_pkg::STAT_N-1:0] status_bit_source,
  input wire logic [sdom_pkg::Q_W-1:0] not_sel [sdom_pkg::NOT_N],
  input wire logic [SLOT_N-1:0] slot_en,
  input wire logic [sdom_pkg::Q_W-1:0] slot_src [SLOT_N],
  input wire logic [sdom_pkg::ORDER_W-1:0] slot_order [SLOT_N],
  input wire logic [SLOT_N-1:0] slot_done,
  input wire logic [sdom_pkg::Q_N-1:0] q_bus,
  input wire logic [sdom_pkg::AND_N-1:0] disc_fault,
  input wire logic [SLOT_N-1:0] order_active,
  input wire logic [sdom_pkg::ORDER_W-1:0] drive_order [SLOT_N]
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_pulse(q);
    q ##1 !q;
  endsequence
  property p_rise;
    !$past(srst) && $rose(status_bit_source[0]) |=> s_pulse(q_bus[44]);
  endproperty
  a_rise: assert property (p_rise) else $error("rise pulse");
  property p_fall;
    !$past(srst) && $fell(status_bit_source[0]) |=> s_pulse(q_bus[45]);
  endproperty
  a_fall: assert property (p_fall) else $error("fall pulse");
  property p_level;
    !$past(srst) |-> q_bus[46] == $past(status_bit_source[0]);
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_inv;
    !$past(srst) |-> q_bus[47] == !$past(status_bit_source[0]);
  endproperty
  a_inv: assert property (p_inv) else $error("inverse wrong");
  property p_not;
    !$past(srst) && $stable(not_sel[0]) && not_sel[0] < 7'h46
      |-> q_bus[21] == !$past(q_bus[not_sel[0]]);
  endproperty
  a_not: assert property (p_not) else $error("not gate wrong");
  property p_disc;
    disc_fault[0] |-> !q_bus[17];
  endproperty
  a_disc: assert property (p_disc) else $error("and in fault");
  property p_order;
    !$past(srst) |-> drive_order[0] == $past(slot_order[0]);
  endproperty
  a_order: assert property (p_order) else $error("order copy");
  property p_off;
    !slot_en[0] |=> !order_active[0];
  endproperty
  a_off: assert property (p_off) else $error("no enable");
  property p_hold;
    slot_src[0] == 7'h2c && slot_en[0] && order_active[0] && !slot_done[0]
      |=> order_active[0];
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped");
  property p_lvl;
    !$past(srst) && $past(slot_src[1]) == 7'h2e
      |-> order_active[1] == ($past(slot_en[1]) && $past(q_bus[46]));
  endproperty
  a_lvl: assert property (p_lvl) else $error("level order wrong");
endmodule

bind sdom_mapper sdom_mapper_asserts #(.SLOT_N(SLOT_N)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .status_bit_source(status_bit_source),
  .not_sel(not_sel), .slot_en(slot_en), .slot_src(slot_src),
  .slot_order(slot_order), .slot_done(slot_done), .q_bus(q_bus),
  .disc_fault(disc_fault), .order_active(order_active),
  .drive_order(drive_order));

`default_nettype wire

// ### verif/tb_top.sv
// bench for the mapper with drive sequencer model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int SN = 8;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [sdom_pkg::STAT_N-1:0] stat_bits = '0;
  logic [sdom_pkg::Q_N-1:0] ext_q = '0;
  logic [sdom_pkg::Q_W-1:0] and_sel [sdom_pkg::AND_N][sdom_pkg::AND_IN];
  logic [sdom_pkg::AND_IN-1:0] and_use [sdom_pkg::AND_N];
  logic [sdom_pkg::AND_N-1:0] disc_en = '0;
  logic [sdom_pkg::DISC_W-1:0] disc_limit = 16'h0002;
  logic [sdom_pkg::Q_W-1:0] or_sel [sdom_pkg::OR_N][sdom_pkg::OR_IN];
  logic [sdom_pkg::OR_IN-1:0] or_use [sdom_pkg::OR_N];
  logic [sdom_pkg::Q_W-1:0] not_sel [sdom_pkg::NOT_N];
  logic [SN-1:0] slot_en = '0;
  logic [sdom_pkg::Q_W-1:0] slot_src [SN];
  logic [sdom_pkg::ORDER_W-1:0] slot_order [SN];
  wire [SN-1:0] slot_done;
  logic [sdom_pkg::Q_N-1:0] q_bus;
  logic [sdom_pkg::AND_N-1:0] disc_fault;
  logic [SN-1:0] order_active;
  logic [sdom_pkg::ORDER_W-1:0] drive_order [SN];
  int err_total = 0;
  int tests_run = 0;
  int n;

  sdom_mapper #(.SLOT_N(SN)) DUT (
    .clk_sys(clk_sys), .srst(srst), .status_bit_source(stat_bits),
    .ext_q(ext_q),
    .and_sel(and_sel), .and_use(and_use), .disc_en(disc_en),
    .disc_limit(disc_limit), .or_sel(or_sel), .or_use(or_use),
    .not_sel(not_sel), .slot_en(slot_en), .slot_src(slot_src),
    .slot_order(slot_order), .slot_done(slot_done), .q_bus(q_bus),
    .disc_fault(disc_fault), .order_active(order_active),
    .drive_order(drive_order));
  sdom_drive_model #(.SLOT_N(SN), .DLY(4)) u_drv (
    .clk_sys(clk_sys), .srst(srst), .order_active(order_active),
    .slot_done(slot_done));

  initial forever #2.5 clk_sys = ~clk_sys;

  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task drv(input logic [4:0] v);
    @(posedge clk_sys);
    stat_bits <= v;
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    // ************************************************************
    // setup: and gates and or0 on levels of bits 0,1; not on bit 0
    // ************************************************************
    and_sel = '{default: '0};
    for (int k = 0; k < sdom_pkg::AND_N; k++) begin
      and_sel[k][0] = 7'h2e;
      and_sel[k][1] = 7'h32;
    end
    and_use = '{4'h3, 4'h3, 4'h3};
    or_sel = '{default: '0};
    or_sel[0][0] = 7'h2e;
    or_sel[0][1] = 7'h32;
    or_use = '{4'h3, 4'h0};
    not_sel = '{7'h2e, 7'h2f};
    slot_src = '{default: '0};
    slot_src[0] = 7'h2c;
    slot_src[1] = 7'h2e;
    for (int k = 0; k < SN; k++) slot_order[k] = 3'(k);
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    cyc(1);
    chk(order_active, 8'h00);
    $display("test reset done");
    @(posedge clk_sys);
    slot_en <= 8'h03;
    stat_bits <= 5'h01;
    cyc(1);
    chk(8'(q_bus[47:44]), 8'h05);
    cyc(1);
    chk(8'(q_bus[47:44]), 8'h04);
    chk(8'(q_bus[22:21]), 8'h02);
    chk({6'h00, q_bus[19], q_bus[17]}, 8'h02);
    chk(order_active, 8'h03);
    chk(8'(drive_order[1]), 8'h01);
    for (n = 0; n < 20 && order_active[0] === 1'b1; n++) cyc(1);
    chk(8'(n >= 3 && n < 20), 8'h01);
    $display("test edges done");
    drv(5'h03);
    cyc(2);
    chk({5'h00, q_bus[64], q_bus[18:17]}, 8'h07);
    // limit 2: fault on third disagreeing cycle, inputs lag one cycle;
    // the middle gate has no discrepancy watch and ignores its enable
    @(posedge clk_sys);
    disc_en <= 3'h7;
    stat_bits <= 5'h01;
    cyc(0);
    for (n = 0; n < 10 && disc_fault[0] !== 1'b1; n++) cyc(1);
    chk(8'(n), 8'h04);
    chk(8'(disc_fault), 8'h05);
    chk(8'(q_bus[17]), 8'h00);
    drv(5'h03);
    cyc(0);
    for (n = 0; n < 10 && disc_fault[0] !== 1'b0; n++) cyc(1);
    chk(8'(n), 8'h02);
    $display("test discrepancy done");
    drv(5'h00);
    cyc(1);
    chk(8'(q_bus[47:44]), 8'h0a);
    cyc(1);
    chk(order_active, 8'h00);
    $display("test fall done");
    summarize();
  end
endmodule

`default_nettype wire

// ### verilog/sdom_mapper.sv
// status bit sources, free logic blocks and drive order assignment
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each status bit gives one-cycle rising and falling edge pulses
// - an order tied to an edge output latches when the pulse comes
// - each status bit gives a level output equal to the bit
// - each status bit gives an output equal to the inverted bit
// - AND block output is the conjunction of its selected inputs
// - some AND blocks add a switchable discrepancy check of inputs
// - OR block output is the disjunction of its selected inputs
// - NOT block output is the negation of its selected input
// - an order assigned to a non-edge output acts only while that output is high
// - every block input picks any source by an index number
module sdom_mapper #(
  parameter int SLOT_N = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [sdom_pkg::STAT_N-1:0] status_bit_source,
  input wire logic [sdom_pkg::Q_N-1:0] ext_q,
  input wire logic [sdom_pkg::Q_W-1:0] and_sel
    [sdom_pkg::AND_N][sdom_pkg::AND_IN],
  input wire logic [sdom_pkg::AND_IN-1:0] and_use [sdom_pkg::AND_N],
  input wire logic [sdom_pkg::AND_N-1:0] disc_en,
  input wire logic [sdom_pkg::DISC_W-1:0] disc_limit,
  input wire logic [sdom_pkg::Q_W-1:0] or_sel
    [sdom_pkg::OR_N][sdom_pkg::OR_IN],
  input wire logic [sdom_pkg::OR_IN-1:0] or_use [sdom_pkg::OR_N],
  input wire logic [sdom_pkg::Q_W-1:0] not_sel [sdom_pkg::NOT_N],
  input wire logic [SLOT_N-1:0] slot_en,
  input wire logic [sdom_pkg::Q_W-1:0] slot_src [SLOT_N],
  input wire logic [sdom_pkg::ORDER_W-1:0] slot_order [SLOT_N],
  input wire logic [SLOT_N-1:0] slot_done,
  output logic [sdom_pkg::Q_N-1:0] q_bus,
  output logic [sdom_pkg::AND_N-1:0] disc_fault,
  output logic [SLOT_N-1:0] order_active,
  output logic [sdom_pkg::ORDER_W-1:0] drive_order [SLOT_N]
);

  localparam int SB = sdom_pkg::STAT_N;

  logic [SB-1:0] sb_rise;
  logic [SB-1:0] sb_fall;
  logic [SB-1:0] sb_level;
  logic [SB-1:0] sb_inv;

  logic [sdom_pkg::AND_N-1:0] and_q;
  logic [sdom_pkg::AND_N-1:0] next_and_q;
  logic [sdom_pkg::OR_N-1:0] or_q;
  logic [sdom_pkg::OR_N-1:0] next_or_q;
  logic [sdom_pkg::NOT_N-1:0] not_q;
  logic [sdom_pkg::NOT_N-1:0] next_not_q;
  logic [sdom_pkg::DISC_W-1:0] disc_cnt [sdom_pkg::AND_N];
  logic [sdom_pkg::DISC_W-1:0] next_disc_cnt [sdom_pkg::AND_N];
  logic [sdom_pkg::AND_N-1:0] next_disc_fault;

  logic [SLOT_N-1:0] latch;
  logic [SLOT_N-1:0] next_latch;
  logic [SLOT_N-1:0] next_order_active;
  logic [sdom_pkg::ORDER_W-1:0] next_drive_order [SLOT_N];

  // out-of-range indices read as an inactive source
  function automatic logic pick(input logic [sdom_pkg::Q_N-1:0] v,
                                input logic [sdom_pkg::Q_W-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < sdom_pkg::Q_N) begin
      r = v[idx];
    end
    return r;
  endfunction

  // ****************************************************************
  // status bit sources
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < SB; g++) begin : g_stat
      sdom_stat_cell u_cell (
        .clk_sys(clk_sys),
        .srst(srst),
        .bit_in(status_bit_source[g]),
        .rise(sb_rise[g]),
        .fall(sb_fall[g]),
        .level(sb_level[g]),
        .inv(sb_inv[g])
      );
    end
  endgenerate

  // ****************************************************************
  // source index space
  // ****************************************************************
  // everything here but ext_q comes from flops, so gates can feed gates
  // without forming a combinational loop
  always_comb begin
    int b;
    b = 0;
    q_bus = ext_q;
    for (int k = 0; k < SB; k++) begin
      b = sdom_pkg::STAT_BASE + k * sdom_pkg::STAT_STRIDE;
      q_bus[b + sdom_pkg::OFS_RISE] = sb_rise[k];
      q_bus[b + sdom_pkg::OFS_FALL] = sb_fall[k];
      q_bus[b + sdom_pkg::OFS_LEVEL] = sb_level[k];
      q_bus[b + sdom_pkg::OFS_INV] = sb_inv[k];
    end
    for (int k = 0; k < sdom_pkg::AND_N; k++) begin
      q_bus[sdom_pkg::AND_Q[k]] = and_q[k];
    end
    for (int k = 0; k < sdom_pkg::OR_N; k++) begin
      q_bus[sdom_pkg::OR_Q[k]] = or_q[k];
    end
    for (int k = 0; k < sdom_pkg::NOT_N; k++) begin
      q_bus[sdom_pkg::NOT_Q[k]] = not_q[k];
    end
  end

  // ****************************************************************
  // free logic blocks
  // ****************************************************************
  always_comb begin
    logic all_hi;
    logic any_hi;
    logic any_lo;
    logic v;
    all_hi = 1'b0;
    any_hi = 1'b0;
    any_lo = 1'b0;
    v = 1'b0;
    next_and_q = '0;
    next_or_q = '0;
    next_not_q = '0;
    next_disc_fault = disc_fault;
    for (int k = 0; k < sdom_pkg::AND_N; k++) begin
      all_hi = |and_use[k];
      any_hi = 1'b0;
      any_lo = 1'b0;
      for (int j = 0; j < sdom_pkg::AND_IN; j++) begin
        v = pick(q_bus, and_sel[k][j]);
        if (and_use[k][j]) begin
          all_hi = all_hi & v;
          any_hi = any_hi | v;
          any_lo = any_lo | ~v;
        end
      end
      next_disc_cnt[k] = '0;
      // inputs that disagree longer than the limit mark a fault;
      // the fault holds the output low until they agree again
      if (sdom_pkg::AND_DISC[k] && disc_en[k]) begin
        if (any_hi && any_lo) begin
          next_disc_cnt[k] = disc_cnt[k];
          if (disc_cnt[k] < disc_limit) begin
            next_disc_cnt[k] = disc_cnt[k] + sdom_pkg::DISC_ONE;
          end else begin
            next_disc_fault[k] = 1'b1;
          end
        end else begin
          next_disc_fault[k] = 1'b0;
        end
      end else begin
        next_disc_fault[k] = 1'b0;
      end
      next_and_q[k] = all_hi & ~next_disc_fault[k];
    end
    for (int k = 0; k < sdom_pkg::OR_N; k++) begin
      for (int j = 0; j < sdom_pkg::OR_IN; j++) begin
        if (or_use[k][j]) begin
          next_or_q[k] = next_or_q[k] | pick(q_bus, or_sel[k][j]);
        end
      end
    end
    for (int k = 0; k < sdom_pkg::NOT_N; k++) begin
      next_not_q[k] = ~pick(q_bus, not_sel[k]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      and_q <= '0;
      or_q <= '0;
      not_q <= '0;
      disc_fault <= '0;
      for (int k = 0; k < sdom_pkg::AND_N; k++) begin
        disc_cnt[k] <= '0;
      end
    end else begin
      and_q <= next_and_q;
      or_q <= next_or_q;
      not_q <= next_not_q;
      disc_fault <= next_disc_fault;
      for (int k = 0; k < sdom_pkg::AND_N; k++) begin
        disc_cnt[k] <= next_disc_cnt[k];
      end
    end
  end

  // ****************************************************************
  // drive order slots
  // ****************************************************************
  // an edge order stays latched until the sequencer reports it done;
  // a new pulse in the same cycle as done keeps it latched
  always_comb begin
    logic hit;
    hit = 1'b0;
    for (int s = 0; s < SLOT_N; s++) begin
      hit = pick(q_bus, slot_src[s]);
      next_latch[s] = 1'b0;
      next_drive_order[s] = slot_order[s];
      if (slot_en[s] && sdom_pkg::is_edge_src(slot_src[s])) begin
        if (hit) begin
          next_latch[s] = 1'b1;
        end else if (slot_done[s]) begin
          next_latch[s] = 1'b0;
        end else begin
          next_latch[s] = latch[s];
        end
        next_order_active[s] = next_latch[s];
      end else begin
        next_order_active[s] = slot_en[s] & hit;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch <= '0;
      order_active <= '0;
      for (int s = 0; s < SLOT_N; s++) begin
        drive_order[s] <= '0;
      end
    end else begin
      latch <= next_latch;
      order_active <= next_order_active;
      for (int s = 0; s < SLOT_N; s++) begin
        drive_order[s] <= next_drive_order[s];
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/sdom_status_bit_source_cell.sv
// edge, level and inverted outputs of one status bit source
`timescale 1ns/1ps
`default_nettype none

module sdom_stat_cell (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic bit_in,
  output logic rise,
  output logic fall,
  output logic level,
  output logic inv
);

  logic next_rise;
  logic next_fall;
  logic next_level;
  logic next_inv;

  // ****************************************************************
  // one evaluation per cycle
  // ****************************************************************
  // level doubles as the previous sample for edge detection
  always_comb begin
    next_rise = bit_in & ~level;
    next_fall = ~bit_in & level;
    next_level = bit_in;
    next_inv = ~bit_in;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rise <= 1'b0;
      fall <= 1'b0;
      level <= 1'b0;
      inv <= 1'b0;
    end else begin
      rise <= next_rise;
      fall <= next_fall;
      level <= next_level;
      inv <= next_inv;
    end
  end

endmodule

`default_nettype wire
